/* File: logic/i2c_master_pkg.sv */
// Functional notes
// - Acknowledge action runs on data read, a read-direction command write, or an owner's address write after a read
// - ack_action is plain storage; 0 sends ACK, 1 sends NACK
// - master_command bits are write strobes and always read as zero
// - Command 0 does nothing; command 1 runs ack action (read direction only) then repeated Start
// - Command 2: read direction acks then receives; write direction sends a byte
// - Command 3 runs ack action (read direction only) then generates a Stop
// - ack_action and command in one write; the new ack_action applies
// - Address, data or command access clears status flags indirectly
// - read_done_flag set on clean byte read after an acknowledged address
// - Writing one clears each of the five flags; zero leaves them
// - write_done_flag set when address or byte write completes, errors or not
// - scl_hold_flag shows SCL held low; cleared by listed accesses
// - received_ack_bit is read-only, last acknowledge from the slave
// - arbitration_lost_flag set on loss during high bit, NACK or Start
// - Software rewrites the address after loss; that clears loss and error
// - bus_error_flag set on illegal Start, repeated Start or Stop
// - Bus error detection needs enabled bus logic and clock at least 4x SCL
// - bus_state_field: 0 unknown, 1 idle, 2 owner, 3 busy
// - Bus state unknown after reset, re-enable and while disabled
// - Writing 1 to bus_state_field forces idle; other values do nothing
// - Address write starts Start or Sr plus address, bit 0 is direction
// - Data write sends a byte, takes the acknowledge, sets write_done_flag
// - Data read sends ack first, receives a byte, sets read or write done
// - The enable bit turns the master function on
package i2c_master_pkg;

  // ----------------------------------------------------------------
  // Register word indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CONTROL_A = 4'h3;
  localparam logic [3:0] IDX_CONTROL_B = 4'h4;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_BIT_RATE = 4'h6;
  localparam logic [3:0] IDX_TARGET_ADDRESS = 4'h7;
  localparam logic [3:0] IDX_DATA = 4'h8;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int CA_ENABLE = 0;
  localparam int CB_FLUSH = 3;
  localparam int CB_ACK_ACTION = 2;
  localparam int ST_READ_DONE = 7;
  localparam int ST_WRITE_DONE = 6;
  localparam int ST_SCL_HOLD = 5;
  localparam int ST_ARB_LOST = 3;
  localparam int ST_BUS_ERROR = 2;
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_OWNER = 2'h2;
  localparam logic [1:0] BUS_BUSY = 2'h3;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h1;
  localparam logic [1:0] CMD_BYTE = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [6:0] {
    SEQ_IDLE = 7'h01,
    SEQ_WAIT = 7'h02,
    SEQ_ACK = 7'h04,
    SEQ_START = 7'h08,
    SEQ_BYTE = 7'h10,
    SEQ_RACK = 7'h20,
    SEQ_STOP = 7'h40
  } seq_state_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_resp_type;

  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } i2c_pins_type;

  typedef struct packed {
    wb_resp_type resp;
    i2c_pins_type pins;
    logic [7:0] control_a;
    logic ack_action;
    logic [7:0] bit_rate_divider;
    logic [7:0] address;
    logic [7:0] shift;
    logic read_done_flag;
    logic write_done_flag;
    logic scl_hold_flag;
    logic received_ack_bit;
    logic arbitration_lost_flag;
    logic bus_error_flag;
    logic [1:0] bus_state_field;
    seq_state_type seq;
    logic [1:0] phase;
    logic [7:0] qcnt;
    logic [2:0] bitcnt;
    logic pend_ack;
    logic pend_start;
    logic pend_byte;
    logic pend_stop;
    logic rx;
    logic report;
    logic read_after;
    logic arb_in_op;
    logic err_in_op;
    logic bit_seen;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
  } core_state_type;

endpackage : i2c_master_pkg

/* File: logic/i2c_master_command_status.sv */
`timescale 1ns/100ps
module i2c_master_command_status
  import i2c_master_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wb_req_type wb_req,
  output wb_resp_type wb_resp,
  input wire logic scl_in,
  input wire logic sda_in,
  output i2c_pins_type pins
);

  core_state_type r;
  core_state_type next_r;

  logic access;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic [7:0] wdat;
  logic enabled;
  logic idle_ready;
  logic start_det;
  logic stop_det;
  logic ours;
  logic active;
  logic quarter;
  logic phase_go;
  logic sda_now;
  logic dispatch;
  logic scl_low;
  logic sda_low;
  logic [7:0] read_value;

  // ----------------------------------------------------------------
  // Bus decode and synchronised line views
  // ----------------------------------------------------------------
  assign access = wb_req.cyc & wb_req.stb & ~r.resp.ack;
  assign wr = access & wb_req.we & wb_req.sel[0];
  assign rd = access & ~wb_req.we;
  assign idx = wb_req.adr[5:2];
  assign wdat = wb_req.dat[7:0];
  assign enabled = r.control_a[CA_ENABLE];
  assign idle_ready = enabled & (r.seq == SEQ_IDLE);
  // Edges are judged on the second and third stages, never the first
  assign start_det = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
  assign stop_det = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
  assign ours = (r.seq == SEQ_START) | (r.seq == SEQ_STOP);
  assign active = (r.seq != SEQ_IDLE) & (r.seq != SEQ_WAIT);
  assign quarter = (r.qcnt == r.bit_rate_divider);
  // Entering the high phase waits for SCL to really rise: slaves may stretch
  assign phase_go = quarter & ((r.phase != PH_RISE) | r.scl_s2);
  assign sda_now = r.sda_s2;

  assign wb_resp = r.resp;
  assign pins = r.pins;

  // Prepare an operation; it leaves WAIT once the bus is not busy
  function automatic core_state_type arm(
    input core_state_type s,
    input logic a,
    input logic st,
    input logic b,
    input logic p,
    input logic rx,
    input logic rep,
    input logic ra
  );
    core_state_type t;
    t = s;
    t.pend_ack = a;
    t.pend_start = st;
    t.pend_byte = b;
    t.pend_stop = p;
    t.rx = rx;
    t.report = rep;
    t.read_after = ra;
    t.arb_in_op = 1'b0;
    t.err_in_op = 1'b0;
    t.seq = SEQ_WAIT;
    return t;
  endfunction : arm

  always_comb begin
    case (idx)
      IDX_CONTROL_A: read_value = r.control_a;
      IDX_CONTROL_B: read_value = {5'h00, r.ack_action, 2'h0};
      IDX_STATUS: read_value = {r.read_done_flag, r.write_done_flag, r.scl_hold_flag,
                                r.received_ack_bit, r.arbitration_lost_flag,
                                r.bus_error_flag, r.bus_state_field};
      IDX_BIT_RATE: read_value = r.bit_rate_divider;
      IDX_TARGET_ADDRESS: read_value = r.address;
      IDX_DATA: read_value = r.shift;
      default: read_value = 8'h00;
    endcase
  end

  always_comb begin
    next_r = r;
    dispatch = 1'b0;
    scl_low = 1'b0;
    sda_low = 1'b0;
    next_r.resp.ack = access;
    next_r.scl_s1 = scl_in;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_s3 = r.scl_s2;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_s3 = r.sda_s2;

    // --------------------------------------------------------------
    // Register accesses: clears come first so that later sets win
    // --------------------------------------------------------------
    if (rd) begin
      next_r.resp.dat = {24'h000000, read_value};
      if (idx == IDX_DATA && idle_ready && r.scl_hold_flag && r.address[0]) begin
        next_r.read_done_flag = 1'b0;
        next_r.write_done_flag = 1'b0;
        next_r.scl_hold_flag = 1'b0;
        next_r = arm(next_r, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      end
    end
    if (wr) begin
      case (idx)
        IDX_CONTROL_A: begin
          next_r.control_a = wdat;
        end
        IDX_CONTROL_B: begin
          next_r.ack_action = wdat[CB_ACK_ACTION];
          if (wdat[CB_FLUSH]) begin
            next_r.seq = SEQ_IDLE;
            next_r.address = REG_RESET;
            next_r.shift = REG_RESET;
            next_r.scl_hold_flag = 1'b0;
            next_r.bus_state_field = BUS_UNKNOWN;
          end else if (wdat[1:0] != CMD_NONE && idle_ready) begin
            next_r.read_done_flag = 1'b0;
            next_r.write_done_flag = 1'b0;
            next_r.scl_hold_flag = 1'b0;
            case (wdat[1:0])
              CMD_RESTART:
                next_r = arm(next_r, r.address[0], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                             1'b0);
              CMD_BYTE:
                next_r = arm(next_r, r.address[0], 1'b0, 1'b1, 1'b0, r.address[0],
                             1'b1, 1'b0);
              CMD_STOP:
                next_r = arm(next_r, r.address[0], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                             1'b0);
              default: next_r.seq = SEQ_IDLE;
            endcase
          end
        end
        IDX_STATUS: begin
          if (wdat[ST_READ_DONE]) next_r.read_done_flag = 1'b0;
          if (wdat[ST_WRITE_DONE]) next_r.write_done_flag = 1'b0;
          if (wdat[ST_SCL_HOLD]) next_r.scl_hold_flag = 1'b0;
          if (wdat[ST_ARB_LOST]) next_r.arbitration_lost_flag = 1'b0;
          if (wdat[ST_BUS_ERROR]) next_r.bus_error_flag = 1'b0;
          if (wdat[1:0] == BUS_IDLE && enabled) next_r.bus_state_field = BUS_IDLE;
        end
        IDX_BIT_RATE: begin
          next_r.bit_rate_divider = wdat;
        end
        IDX_TARGET_ADDRESS: begin
          next_r.address = wdat;
          next_r.read_done_flag = 1'b0;
          next_r.write_done_flag = 1'b0;
          next_r.scl_hold_flag = 1'b0;
          next_r.arbitration_lost_flag = 1'b0;
          next_r.bus_error_flag = 1'b0;
          if (idle_ready) begin
            if (r.bus_state_field == BUS_UNKNOWN) begin
              // Nothing is known about the bus, so refuse at once
              next_r.write_done_flag = 1'b1;
              next_r.bus_error_flag = 1'b1;
            end else begin
              next_r.shift = wdat;
              next_r = arm(next_r, r.address[0] & (r.bus_state_field == BUS_OWNER), 1'b1,
                           1'b1, 1'b0, 1'b0, 1'b1, wdat[0]);
            end
          end
        end
        IDX_DATA: begin
          // Writes during shifting are dropped to protect the byte on the wire
          if (idle_ready) begin
            next_r.shift = wdat;
            next_r.read_done_flag = 1'b0;
            next_r.write_done_flag = 1'b0;
            next_r.scl_hold_flag = 1'b0;
            next_r = arm(next_r, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
          end
        end
        default: begin
          next_r.resp.dat = r.resp.dat;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Bit sequencer: four phases of divider+1 cycles each
    // --------------------------------------------------------------
    if (r.seq == SEQ_WAIT && r.bus_state_field != BUS_BUSY) begin
      dispatch = 1'b1;
    end
    if (active) begin
      if (!quarter) begin
        next_r.qcnt = r.qcnt + 8'h01;
      end else if (phase_go) begin
        next_r.qcnt = 8'h00;
        next_r.phase = r.phase + 2'h1;
        case (r.seq)
          SEQ_START: begin
            if (r.phase == PH_RISE && !sda_now) begin
              next_r.arbitration_lost_flag = 1'b1;
              next_r.write_done_flag = 1'b1;
              next_r.bus_state_field = BUS_BUSY;
              next_r.seq = SEQ_IDLE;
            end else if (r.phase == PH_FALL) begin
              next_r.bus_state_field = BUS_OWNER;
              dispatch = 1'b1;
            end
          end
          SEQ_ACK: begin
            if (r.phase == PH_HIGH && r.ack_action && !sda_now && !r.arb_in_op) begin
              next_r.arbitration_lost_flag = 1'b1;
              next_r.arb_in_op = 1'b1;
            end
            if (r.phase == PH_FALL) dispatch = 1'b1;
          end
          SEQ_BYTE: begin
            if (r.phase == PH_HIGH) begin
              next_r.shift = {r.shift[6:0], sda_now};
              if (!r.rx && !r.arb_in_op && r.shift[7] && !sda_now) begin
                next_r.arbitration_lost_flag = 1'b1;
                next_r.arb_in_op = 1'b1;
              end
            end
            if (r.phase == PH_FALL) begin
              if (r.bitcnt != LAST_BIT) begin
                next_r.bitcnt = r.bitcnt + 3'h1;
              end else if (r.rx) begin
                dispatch = 1'b1;
              end else begin
                next_r.seq = SEQ_RACK;
              end
            end
          end
          SEQ_RACK: begin
            if (r.phase == PH_HIGH) next_r.received_ack_bit = sda_now;
            if (r.phase == PH_FALL) begin
              // A read address goes on to one byte only after the slave acked
              if (r.read_after && !r.received_ack_bit && !r.arb_in_op) begin
                next_r.pend_byte = 1'b1;
                next_r.rx = 1'b1;
              end
              dispatch = 1'b1;
            end
          end
          SEQ_STOP: begin
            if (r.phase == PH_FALL) begin
              next_r.bus_state_field = BUS_IDLE;
              dispatch = 1'b1;
            end
          end
          default: next_r.seq = SEQ_IDLE;
        endcase
      end
    end
    if (dispatch) begin
      next_r.phase = 2'h0;
      next_r.qcnt = 8'h00;
      next_r.bitcnt = 3'h0;
      if (next_r.pend_ack) begin
        next_r.pend_ack = 1'b0;
        next_r.seq = SEQ_ACK;
      end else if (next_r.pend_start) begin
        next_r.pend_start = 1'b0;
        next_r.seq = SEQ_START;
      end else if (next_r.pend_byte) begin
        next_r.pend_byte = 1'b0;
        next_r.seq = SEQ_BYTE;
      end else if (next_r.pend_stop) begin
        next_r.pend_stop = 1'b0;
        next_r.seq = SEQ_STOP;
      end else begin
        next_r.seq = SEQ_IDLE;
        if (r.seq != SEQ_STOP) begin
          // After losing the bus the clock is no longer ours to hold
          next_r.scl_hold_flag = ~r.arb_in_op;
          if (r.arb_in_op) next_r.bus_state_field = BUS_BUSY;
          if (r.report) begin
            if (r.rx && !r.arb_in_op && !r.err_in_op) begin
              next_r.read_done_flag = 1'b1;
            end else begin
              next_r.write_done_flag = 1'b1;
            end
          end
        end
      end
    end

    // --------------------------------------------------------------
    // Bus monitor: conditions made by others
    // --------------------------------------------------------------
    if (enabled) begin
      if (start_det) begin
        next_r.bit_seen = 1'b0;
      end else if (r.scl_s2 && !r.scl_s3) begin
        next_r.bit_seen = 1'b1;
      end
      // Needs the core clock at least four times SCL to see both edges
      if (!ours && ((start_det || stop_det) && r.bus_state_field == BUS_OWNER ||
                    stop_det && !r.bit_seen)) begin
        next_r.bus_error_flag = 1'b1;
        next_r.err_in_op = active;
      end
      if (!ours && start_det) next_r.bus_state_field = BUS_BUSY;
      if (!ours && stop_det) next_r.bus_state_field = BUS_IDLE;
    end

    // --------------------------------------------------------------
    // Disable and line drive
    // --------------------------------------------------------------
    if (!next_r.control_a[CA_ENABLE]) begin
      next_r.seq = SEQ_IDLE;
      next_r.scl_hold_flag = 1'b0;
      next_r.bus_state_field = BUS_UNKNOWN;
    end
    scl_low = (next_r.phase == 2'h0) | (next_r.phase == PH_FALL && next_r.seq != SEQ_STOP);
    sda_low = ~r.pins.sda_oe_n;
    case (next_r.seq)
      SEQ_IDLE: begin
        scl_low = next_r.scl_hold_flag;
        sda_low = next_r.scl_hold_flag & ~r.pins.sda_oe_n;
      end
      SEQ_WAIT: scl_low = ~r.pins.scl_oe_n;
      SEQ_START: sda_low = next_r.phase[1];
      SEQ_STOP: sda_low = next_r.phase != PH_FALL;
      SEQ_ACK: begin
        if (next_r.phase == 2'h0) sda_low = ~next_r.ack_action & ~next_r.arb_in_op;
      end
      SEQ_BYTE: begin
        // Only 1s go out once arbitration is lost
        if (next_r.phase == 2'h0) begin
          sda_low = ~next_r.rx & ~next_r.arb_in_op & ~next_r.shift[7];
        end
      end
      SEQ_RACK: begin
        if (next_r.phase == 2'h0) sda_low = 1'b0;
      end
      default: scl_low = 1'b0;
    endcase
    next_r.pins.scl_out = 1'b0;
    next_r.pins.sda_out = 1'b0;
    next_r.pins.scl_oe_n = ~scl_low;
    next_r.pins.sda_oe_n = ~sda_low;

    if (!rst_n) begin
      next_r = '0;
      next_r.seq = SEQ_IDLE;
      next_r.pins.scl_oe_n = 1'b1;
      next_r.pins.sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= next_r;
  end

endmodule : i2c_master_command_status

/* File: verif/i2c_master_command_status_props.sv */
`timescale 1ns/100ps
module i2c_master_command_status_props
  import i2c_master_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wb_req_type wb_req,
  input wire wb_resp_type wb_resp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire i2c_pins_type pins
);
  // ----------------------------------------------------------------
  // Shadow of the enable and ack action bits
  // ----------------------------------------------------------------
  logic aa;
  logic en;
  logic [2:0] off_cnt;
  wire req = wb_req.cyc && wb_req.stb && !wb_resp.ack;
  wire wr0 = req && wb_req.we && wb_req.sel[0];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aa <= 1'b0;
      en <= 1'b0;
      off_cnt <= 3'h0;
    end else begin
      if (wr0 && wb_req.adr[5:2] == IDX_CONTROL_B) aa <= wb_req.dat[CB_ACK_ACTION];
      if (wr0 && wb_req.adr[5:2] == IDX_CONTROL_A) en <= wb_req.dat[CA_ENABLE];
      // Saturates so a long disabled stretch reads as settled
      if (en) off_cnt <= 3'h0;
      else if (off_cnt != 3'h7) off_cnt <= off_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_read(logic [3:0] i);
    req && !wb_req.we && wb_req.adr[5:2] == i;
  endsequence
  sequence s_status_read;
    s_read(IDX_STATUS) ##1 wb_resp.ack;
  endsequence
  a_ack_after_req: assert property (req |=> wb_resp.ack)
    else $error("access not answered next cycle");
  a_ack_one_pulse: assert property (wb_resp.ack |=> !wb_resp.ack)
    else $error("ack longer than one cycle");
  a_read_data_held: assert property (!wb_resp.ack |-> $stable(wb_resp.dat))
    else $error("read data moved without a read");
  a_ctrlb_readback: assert property (
    s_read(IDX_CONTROL_B) |=> wb_resp.dat[3:0] == {1'b0, aa, 2'b00})
    else $error("control_b readback wrong");
  a_unmapped_zero: assert property (s_read(4'h0) |=> wb_resp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_hold_scl_low: assert property (
    s_status_read ##0 wb_resp.dat[ST_SCL_HOLD] |-> !pins.scl_oe_n)
    else $error("hold flag without scl low");
  a_off_unknown: assert property (
    s_read(IDX_STATUS) ##0 off_cnt == 3'h7 |=> wb_resp.dat[1:0] == BUS_UNKNOWN)
    else $error("bus state known while disabled");
  a_off_released: assert property (
    off_cnt == 3'h7 |-> pins.scl_oe_n && pins.sda_oe_n)
    else $error("lines driven while disabled");
  a_open_drain: assert property (!pins.scl_out && !pins.sda_out)
    else $error("open drain output not low");
  a_reset_release: assert property (
    $rose(rst_n) |-> pins.scl_oe_n && pins.sda_oe_n)
    else $error("lines driven after reset");
endmodule : i2c_master_command_status_props

bind i2c_master_command_status i2c_master_command_status_props props (
  .core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_resp(wb_resp),
  .scl_in(scl_in), .sda_in(sda_in), .pins(pins));

/* File: verif/i2c_slave_model.sv */
`timescale 1ns/100ps
module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic [7:0] tx_byte,
  output logic sda_n,
  output logic [7:0] rx_byte,
  output logic mack,
  output int starts
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hff;
  int cnt = 99;
  logic adr_ph = 1'b0;
  logic rd = 1'b0;
  initial begin
    sda_n = 1'b1;
    rx_byte = 8'h00;
    mack = 1'b1;
    starts = 0;
  end
  always @(negedge sda) begin
    if (scl) begin
      // Start's own scl fall is not a bit, hence minus one
      cnt = -1;
      adr_ph = 1'b1;
      rd = 1'b0;
      sda_n = 1'b1;
      starts = starts + 1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      cnt = 99;
      rd = 1'b0;
      sda_n = 1'b1;
    end
  end
  always @(posedge scl) begin
    if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 8) mack = sda;
  end
  always @(negedge scl) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      if (adr_ph || !rd) begin
        rx_byte = sh;
        sda_n = nack;
        rd = adr_ph ? (sh[0] && !nack) : rd;
      end else begin
        sda_n = 1'b1;
      end
    end else if (cnt == 9) begin
      cnt = 0;
      adr_ph = 1'b0;
      tx = tx_byte;
      sda_n = !(rd && !mack) || tx[7];
    end else if (cnt > 0 && cnt < 8 && rd && !adr_ph) begin
      sda_n = tx[7 - cnt];
    end
  end
endmodule : i2c_slave_model

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
  import i2c_master_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wb_req_type wb_req = '0;
  wb_resp_type wb_resp;
  i2c_pins_type pins;
  logic ext_sda_n = 1'b1;
  logic nack = 1'b0;
  logic [7:0] tx_byte = 8'hc3;
  logic slv_sda_n;
  logic [7:0] rx_byte;
  logic mack;
  int starts;
  logic [7:0] q;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  // Pull-ups: a released or unknown driver reads high
  wire scl = (pins.scl_oe_n !== 1'b0);
  wire sda = (pins.sda_oe_n !== 1'b0) && slv_sda_n && ext_sda_n;
  always #4 core_clk = ~core_clk;
  i2c_master_command_status dut (.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_resp(wb_resp), .scl_in(scl), .sda_in(sda), .pins(pins));
  i2c_slave_model slave (.scl(scl), .sda(sda), .nack(nack), .tx_byte(tx_byte),
    .sda_n(slv_sda_n), .rx_byte(rx_byte), .mack(mack), .starts(starts));
  // ----------------------------------------------------------------
  // Bus cycle and compare helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic we, input logic [5:0] adr, input logic [7:0] d);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: {24'h0, d}};
    // Ack is watched mid-cycle, where it has settled, and taken at the next edge
    do begin
      @(negedge core_clk);
    end while (wb_resp.ack !== 1'b1);
    @(posedge core_clk);
    q = wb_resp.dat[7:0];
    wb_req <= '0;
  endtask : xfer
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_st(input logic [7:0] mask, input logic [7:0] val);
    int t;
    t = 0;
    do begin
      xfer(1'b0, 6'h14, 8'h00);
      t++;
    end while ((q & mask) !== val && t < 300);
    chk(q & mask, val);
  endtask : wait_st
  task automatic test_done();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    logic [5:0] a[5] = '{6'h00, 6'h10, 6'h14, 6'h18, 6'h1c};
    foreach (a[i]) begin
      xfer(1'b0, a[i], 8'h00);
      chk(q, 8'h00);
    end
    xfer(1'b1, 6'h10, 8'h07);
    xfer(1'b0, 6'h10, 8'h00);
    chk(q, 8'h04);
    xfer(1'b1, 6'h10, 8'h00);
    xfer(1'b0, 6'h10, 8'h00);
    chk(q, 8'h00);
  endtask : t_reset_values
  task automatic t_unknown_bus();
    xfer(1'b1, 6'h18, 8'h01);
    xfer(1'b1, 6'h0c, 8'h01);
    xfer(1'b1, 6'h1c, 8'ha0);
    wait_st(8'hff, 8'h44);
    xfer(1'b1, 6'h14, 8'h02);
    wait_st(8'hff, 8'h44);
    xfer(1'b1, 6'h14, 8'h44);
    wait_st(8'hff, 8'h00);
    xfer(1'b1, 6'h14, 8'h01);
    wait_st(8'hff, 8'h01);
  endtask : t_unknown_bus
  task automatic t_write_path();
    xfer(1'b1, 6'h1c, 8'ha0);
    wait_st(8'h40, 8'h40);
    wait_st(8'hff, 8'h62);
    chk(rx_byte, 8'ha0);
    xfer(1'b1, 6'h10, 8'h00);
    wait_st(8'hff, 8'h62);
    nack <= 1'b1;
    xfer(1'b1, 6'h20, 8'h5a);
    wait_st(8'hff, 8'h02);
    wait_st(8'h40, 8'h40);
    wait_st(8'hff, 8'h72);
    chk(rx_byte, 8'h5a);
    nack <= 1'b0;
    xfer(1'b1, 6'h10, 8'h01);
    wait_st(8'hff, 8'h32);
    chk(starts[7:0], 8'h02);
    xfer(1'b1, 6'h10, 8'h02);
    wait_st(8'hff, 8'h62);
    xfer(1'b1, 6'h10, 8'h03);
    wait_st(8'hff, 8'h01);
    chk({7'h0, scl}, 8'h01);
  endtask : t_write_path
  task automatic t_read_path();
    xfer(1'b1, 6'h1c, 8'ha1);
    wait_st(8'h80, 8'h80);
    wait_st(8'hff, 8'ha2);
    tx_byte <= 8'h3c;
    xfer(1'b0, 6'h20, 8'h00);
    chk(q, 8'hc3);
    wait_st(8'h80, 8'h80);
    wait_st(8'hff, 8'ha2);
    chk({7'h0, mack}, 8'h00);
    tx_byte <= 8'h96;
    xfer(1'b1, 6'h10, 8'h02);
    wait_st(8'h80, 8'h80);
    wait_st(8'hff, 8'ha2);
    chk({7'h0, mack}, 8'h00);
    xfer(1'b1, 6'h10, 8'h07);
    wait_st(8'hff, 8'h01);
    chk({7'h0, mack}, 8'h01);
    // Not holding, so this read only returns the last byte received
    xfer(1'b0, 6'h20, 8'h00);
    chk(q, 8'h96);
    xfer(1'b1, 6'h10, 8'h0c);
    xfer(1'b0, 6'h10, 8'h00);
    chk(q, 8'h04);
    wait_st(8'h03, 8'h00);
    xfer(1'b0, 6'h1c, 8'h00);
    chk(q, 8'h00);
  endtask : t_read_path
  task automatic t_faults();
    @(posedge core_clk);
    ext_sda_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    ext_sda_n <= 1'b1;
    wait_st(8'h04, 8'h04);
    xfer(1'b1, 6'h1c, 8'ha0);
    wait (sda == 1'b0);
    wait (scl == 1'b0);
    @(posedge core_clk);
    ext_sda_n <= 1'b0;
    wait_st(8'h40, 8'h40);
    wait_st(8'h4c, 8'h48);
    ext_sda_n <= 1'b1;
    xfer(1'b1, 6'h0c, 8'h00);
    repeat (4) @(posedge core_clk);
    wait_st(8'h03, 8'h00);
  endtask : t_faults
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("MISMATCH t=%0t run did not finish in time", $time);
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_unknown_bus();
    t_write_path();
    t_read_path();
    t_faults();
    test_done();
  end
endmodule : tb
